// [rtl/pfsa_pkg.sv]
// Shared constants and types of the program flash self-access block.
package pfsa_pkg;

  localparam int AXI_AW = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_ADR_LO = 8'h00;
  localparam logic [7:0] OFS_ADR_HI = 8'h04;
  localparam logic [7:0] OFS_DAT_LO = 8'h08;
  localparam logic [7:0] OFS_DAT_HI = 8'h0C;
  localparam logic [7:0] OFS_CTL    = 8'h10;
  localparam logic [7:0] OFS_UNLOCK = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Field positions of nv_control_reg.
  localparam int CTL_RD  = 0;
  localparam int CTL_WR  = 1;
  localparam int CTL_WEN = 2;
  localparam int CTL_ERR = 3;
  localparam int CTL_PGD = 7;

  // Field positions of the status register.
  localparam int STS_ARMED = 0;
  localparam int STS_WRTOK = 1;
  localparam int STS_STALL = 2;

  localparam int FL_AW = 13;
  localparam int FL_DW = 14;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: read fetch and write setup each take two instruction cycles.
  localparam int          CLK_PERIOD_NS = 100;
  localparam logic [1:0]  SETUP_CYCLES  = 2'h2;
  localparam int          PROG_TIME_NS  = 2000000;
  localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} pfsa_unlock_t;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [FL_AW-1:0] addr;
    logic [FL_DW-1:0] wdata;
  } pfsa_fl_req_t;

  typedef struct packed {
    logic             rd_valid;
    logic [FL_DW-1:0] rdata;
    logic             busy;
    logic             done;
  } pfsa_fl_rsp_t;

endpackage : pfsa_pkg

// [rtl/pfsa_flash_array.sv]
// Program flash array with one-cycle read and timed word programming.
`timescale 1ns/100ps
`default_nettype none
module pfsa_flash_array #(
  parameter int PROG_CYCLES = pfsa_pkg::PROG_CYCLES
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire pfsa_pkg::pfsa_fl_req_t req,
  output var  pfsa_pkg::pfsa_fl_rsp_t rsp
);

  localparam int CW = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    pfsa_pkg::pfsa_fl_rsp_t          rsp;
    logic [CW-1:0]                   cnt;
    logic [pfsa_pkg::FL_AW-1:0]      waddr;
    logic [pfsa_pkg::FL_DW-1:0]      wdata;
  } pfsa_fl_st_t;

  logic [pfsa_pkg::FL_DW-1:0] mem_r [2**pfsa_pkg::FL_AW];
  pfsa_fl_st_t                st_r;
  pfsa_fl_st_t                st_nxt;

  always_comb begin
    st_nxt              = st_r;
    st_nxt.rsp.rd_valid = 1'b0;
    st_nxt.rsp.done     = 1'b0;
    if (req.rd) begin
      st_nxt.rsp.rd_valid = 1'b1;
      st_nxt.rsp.rdata    = mem_r[req.addr];
    end
    if (st_r.rsp.busy) begin
      if (st_r.cnt == '0) begin
        st_nxt.rsp.busy = 1'b0;
        st_nxt.rsp.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end else if (req.wr) begin
      st_nxt.rsp.busy = 1'b1;
      st_nxt.cnt      = CW'(PROG_CYCLES - 1);
      st_nxt.waddr    = req.addr;
      st_nxt.wdata    = req.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The cell only changes when the programming time has fully elapsed.
  always_ff @(posedge aclk) begin
    if (st_r.rsp.busy && st_r.cnt == '0) begin
      mem_r[st_r.waddr] <= st_r.wdata;
    end
  end

  assign rsp = st_r.rsp;

endmodule : pfsa_flash_array
`default_nettype wire

// [rtl/pfsa_top.sv]
// AXI4-Lite register front end and sequencer for flash self-access.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RL1] Read start fetches the word over two cycles, then data registers load.
// [RL2] Data registers hold until the next read or a firmware write.
// [RL3] Firmware loads address, sets memory select, then sets read start.
// [RL4] During programming the core is stalled; clock and peripherals run.
// [RL5] Stall drops when programming ends so the core resumes.
// [RL6] Write-protect configuration low blocks every flash write.
// [RL7] Write start needs write enable set by an earlier access.
// [RL8] Clearing write enable does not abort a write in progress.
// [RL9] Firmware writes 55h then AAh to unlock, then sets write start.
// [RL10] Firmware runs two idle instructions after write start.
// [RL11] Firmware places the 14-bit word in the data register pair.
// [RL12] Firmware sets memory select and write enable before unlocking.
// [RL13] Firmware should keep write enable clear outside writes.
// [RL14] Firmware masks interrupts across unlock and trailing idles.
// [RL15] Firmware keeps the address within the implemented memory.
// [RL16] A broken unlock sequence ignores the write request.
module pfsa_top #(
  parameter int PROG_CYCLES = pfsa_pkg::PROG_CYCLES
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [pfsa_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pfsa_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        flash_write_protect_cfg,
  output logic                             cpu_stall
);

  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic                        aw_held;
    logic [7:0]                  aw_addr;
    logic                        w_held;
    logic [7:0]                  wdata;
    logic                        wstrb0;
    logic [7:0]                  adr_lo;
    logic [4:0]                  adr_hi;
    logic [7:0]                  dat_lo;
    logic [5:0]                  dat_hi;
    logic                        ctl_rd;
    logic                        ctl_wr;
    logic                        ctl_wen;
    logic                        ctl_err;
    logic                        ctl_pgd;
    pfsa_pkg::pfsa_unlock_t      ul;
    logic                        rd_go;
    logic                        wr_pend;
    logic [1:0]                  setup_cnt;
    logic                        wr_go;
    logic                        stall;
    logic                        wrt_meta;
    logic                        wrt_ok;
  } pfsa_st_t;

  pfsa_st_t               st_r;
  pfsa_st_t               st_nxt;
  pfsa_pkg::pfsa_fl_req_t fl_req;
  pfsa_pkg::pfsa_fl_rsp_t fl_rsp;
  logic [7:0]             ctl_byte;
  logic [7:0]             sts_byte;

  assign ctl_byte = {st_r.ctl_pgd, 3'h0, st_r.ctl_err, st_r.ctl_wen,
                     st_r.ctl_wr, st_r.ctl_rd};
  assign sts_byte = {5'h00, st_r.stall, st_r.wrt_ok,
                     st_r.ul == pfsa_pkg::UL_ARMED};

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rd_go = 1'b0;
    st_nxt.wr_go = 1'b0;
    // The pin is asynchronous; only the second stage is ever read.
    st_nxt.wrt_meta = flash_write_protect_cfg;
    st_nxt.wrt_ok   = st_r.wrt_meta;

    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata[7:0];
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // A write commits once address and data are both held.
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = pfsa_pkg::RESP_OKAY;
      // Any other register write between the keys breaks the unlock sequence; reads do not.
      st_nxt.ul      = pfsa_pkg::UL_IDLE; // RL16
      unique case (st_r.aw_addr)
        pfsa_pkg::OFS_ADR_LO: begin
          if (st_r.wstrb0) begin
            st_nxt.adr_lo = st_r.wdata;
          end
        end
        pfsa_pkg::OFS_ADR_HI: begin
          if (st_r.wstrb0) begin
            st_nxt.adr_hi = st_r.wdata[4:0];
          end
        end
        pfsa_pkg::OFS_DAT_LO: begin
          if (st_r.wstrb0) begin
            st_nxt.dat_lo = st_r.wdata; // RL2
          end
        end
        pfsa_pkg::OFS_DAT_HI: begin
          if (st_r.wstrb0) begin
            st_nxt.dat_hi = st_r.wdata[5:0]; // RL2
          end
        end
        pfsa_pkg::OFS_UNLOCK: begin
          if (st_r.wstrb0 && st_r.wdata == pfsa_pkg::UNLOCK_KEY1) begin
            st_nxt.ul = pfsa_pkg::UL_KEY1;
          end else if (st_r.wstrb0 && st_r.ul == pfsa_pkg::UL_KEY1 &&
                       st_r.wdata == pfsa_pkg::UNLOCK_KEY2) begin
            st_nxt.ul = pfsa_pkg::UL_ARMED;
          end
        end
        pfsa_pkg::OFS_CTL: begin
          if (st_r.wstrb0) begin
            st_nxt.ctl_pgd = st_r.wdata[pfsa_pkg::CTL_PGD];
            // Clearing enable here never touches a write already running.
            st_nxt.ctl_wen = st_r.wdata[pfsa_pkg::CTL_WEN]; // RL8
            if (!st_r.wdata[pfsa_pkg::CTL_ERR]) begin
              st_nxt.ctl_err = 1'b0;
            end
            if (st_r.wdata[pfsa_pkg::CTL_RD] &&
                st_r.wdata[pfsa_pkg::CTL_PGD] && !st_r.ctl_rd) begin
              st_nxt.ctl_rd = 1'b1; // RL1
              st_nxt.rd_go  = 1'b1; // RL1
            end
            if (st_r.wdata[pfsa_pkg::CTL_WR] && !st_r.ctl_wr) begin
              // Enable must predate this access; keys must be fresh.
              if (st_r.ctl_wen && st_r.ul == pfsa_pkg::UL_ARMED && // RL7
                  st_r.wdata[pfsa_pkg::CTL_PGD] &&
                  st_r.wrt_ok) begin // RL6
                st_nxt.ctl_wr    = 1'b1;
                st_nxt.wr_pend   = 1'b1;
                st_nxt.setup_cnt = pfsa_pkg::SETUP_CYCLES - 2'h1;
                st_nxt.stall     = 1'b1; // RL4
              end else begin
                // Refused start; set wins over the clear above.
                st_nxt.ctl_err = 1'b1; // RL16
              end
            end
          end
        end
        pfsa_pkg::OFS_STATUS: begin
        end
        default: begin
          st_nxt.bresp = pfsa_pkg::RESP_SLVERR;
        end
      endcase
    end

    // The fetched word lands two cycles after the read start.
    if (fl_rsp.rd_valid) begin
      st_nxt.dat_lo = fl_rsp.rdata[7:0]; // RL1
      st_nxt.dat_hi = fl_rsp.rdata[13:8]; // RL1
      st_nxt.ctl_rd = 1'b0;
    end

    // Two setup cycles mirror the idle instructions after write start.
    if (st_r.wr_pend) begin
      if (st_r.setup_cnt == 2'h0) begin
        st_nxt.wr_pend = 1'b0;
        st_nxt.wr_go   = 1'b1;
      end else begin
        st_nxt.setup_cnt = st_r.setup_cnt - 2'h1;
      end
    end
    if (fl_rsp.done) begin
      st_nxt.stall  = 1'b0; // RL5
      st_nxt.ctl_wr = 1'b0;
    end

    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = pfsa_pkg::RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        pfsa_pkg::OFS_ADR_LO: st_nxt.rdata[7:0] = st_r.adr_lo;
        pfsa_pkg::OFS_ADR_HI: st_nxt.rdata[4:0] = st_r.adr_hi;
        pfsa_pkg::OFS_DAT_LO: st_nxt.rdata[7:0] = st_r.dat_lo;
        pfsa_pkg::OFS_DAT_HI: st_nxt.rdata[5:0] = st_r.dat_hi;
        pfsa_pkg::OFS_CTL:    st_nxt.rdata[7:0] = ctl_byte;
        pfsa_pkg::OFS_UNLOCK: st_nxt.rdata[7:0] = 8'h00;
        pfsa_pkg::OFS_STATUS: st_nxt.rdata[7:0] = sts_byte;
        default:              st_nxt.rresp = pfsa_pkg::RESP_SLVERR;
      endcase
    end

    // While stalled the core issues nothing, so both address
    // channels are closed; responses already owed still drain.
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid && !st_nxt.stall; // RL4
    st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid && !st_nxt.stall; // RL4
    st_nxt.arready = !st_nxt.rvalid && !st_nxt.stall; // RL4
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= '0;
      st_r.adr_lo  <= pfsa_pkg::RST_BYTE;
      st_r.dat_lo  <= pfsa_pkg::RST_BYTE;
      st_r.ul      <= pfsa_pkg::UL_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fl_req.rd    = st_r.rd_go;
  assign fl_req.wr    = st_r.wr_go;
  assign fl_req.addr  = {st_r.adr_hi, st_r.adr_lo};
  assign fl_req.wdata = {st_r.dat_hi, st_r.dat_lo};

  pfsa_flash_array #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_array (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (fl_req),
    .rsp     (fl_rsp)
  );

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = st_r.rdata;
  assign cpu_stall     = st_r.stall;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rd_two;
    $rose(st_r.ctl_rd) |-> ##1 st_r.ctl_rd ##1 !st_r.ctl_rd;
  endproperty
  a_rd_two: assert property (p_rd_two) else $error("read not two cycles"); // RL1

  property p_rd_data;
    fl_rsp.rd_valid |=> {st_r.dat_hi, st_r.dat_lo} == $past(fl_rsp.rdata);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data lost"); // RL1

  property p_hold;
    !fl_rsp.rd_valid && !(st_r.aw_held && st_r.w_held && !st_r.bvalid)
      |=> $stable(st_r.dat_lo) && $stable(st_r.dat_hi);
  endproperty
  a_hold: assert property (p_hold) else $error("data changed"); // RL2

  property p_stall;
    fl_rsp.busy |-> st_r.stall && !st_r.arready && !st_r.awready;
  endproperty
  a_stall: assert property (p_stall) else $error("core not stalled"); // RL4

  property p_resume;
    fl_rsp.done |=> !st_r.stall && !st_r.ctl_wr;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // RL5

  property p_protect;
    st_r.wr_pend && !$past(st_r.wr_pend) |-> $past(st_r.wrt_ok);
  endproperty
  a_protect: assert property (p_protect) else $error("protect bypassed"); // RL6

  property p_wen_first;
    $rose(st_r.wr_pend) |-> $past(st_r.ctl_wen) ##2 fl_req.wr;
  endproperty
  a_wen_first: assert property (p_wen_first) else $error("bad start"); // RL7

  property p_no_abort;
    fl_rsp.busy && !$rose(fl_rsp.busy) |-> $past(fl_rsp.busy) && st_r.ctl_wr;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("write aborted"); // RL8

  property p_unlock;
    $rose(st_r.wr_pend) |-> $past(st_r.ul) == pfsa_pkg::UL_ARMED;
  endproperty
  a_unlock: assert property (p_unlock) else $error("not unlocked"); // RL16

endmodule : pfsa_top
`default_nettype wire

// [dv/pfsa_fw_model.sv]
// Firmware model that reaches the flash block over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pfsa_fw_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    awaddr  = 8'h00;
    awvalid = 1'h0;
    wdata   = 32'h0;
    wvalid  = 1'h0;
    bready  = 1'h0;
    araddr  = 8'h00;
    arvalid = 1'h0;
    rready  = 1'h0;
  end

  // Payload is inverted once taken, so a stale value never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'h1;
    wdata   <= {24'h0, d};
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'h0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'h0;
        wdata  <= ~wdata;
      end
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'h0;
        araddr  <= ~a;
      end
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    d = rdata;
    resp = rresp;
  endtask : rd

  // Interrupts are never raised here, so the unlock runs unbroken.
  task automatic flash_write(input logic [12:0] a, input logic [13:0] d);
    logic [1:0] r;
    wr(pfsa_pkg::OFS_ADR_LO, a[7:0], r);
    wr(pfsa_pkg::OFS_ADR_HI, {3'h0, a[12:8]}, r);
    wr(pfsa_pkg::OFS_DAT_LO, d[7:0], r);
    wr(pfsa_pkg::OFS_DAT_HI, {2'h0, d[13:8]}, r);
    wr(pfsa_pkg::OFS_CTL, 8'h84, r);
    wr(pfsa_pkg::OFS_UNLOCK, pfsa_pkg::UNLOCK_KEY1, r);
    wr(pfsa_pkg::OFS_UNLOCK, pfsa_pkg::UNLOCK_KEY2, r);
    wr(pfsa_pkg::OFS_CTL, 8'h86, r);
    repeat (2) @(posedge aclk);
    wr(pfsa_pkg::OFS_CTL, 8'h80, r);
  endtask : flash_write

  task automatic flash_read(input logic [12:0] a, output logic [13:0] d);
    logic [1:0]  r;
    logic [31:0] lo;
    logic [31:0] hi;
    wr(pfsa_pkg::OFS_ADR_LO, a[7:0], r);
    wr(pfsa_pkg::OFS_ADR_HI, {3'h0, a[12:8]}, r);
    wr(pfsa_pkg::OFS_CTL, 8'h80, r);
    wr(pfsa_pkg::OFS_CTL, 8'h81, r);
    repeat (2) @(posedge aclk);
    rd(pfsa_pkg::OFS_DAT_LO, lo, r);
    rd(pfsa_pkg::OFS_DAT_HI, hi, r);
    d = {hi[5:0], lo[7:0]};
  endtask : flash_read
endmodule : pfsa_fw_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the flash self-access block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); \
  end \
end
module testbench;
  localparam int PC = 8;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        wp = 1'h1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cpu_stall;
  logic [13:0] fd;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          stall_cyc = 0;
  int          s0;

  always #50 aclk = ~aclk;

  pfsa_top #(.PROG_CYCLES(PC)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_write_protect_cfg(wp),
    .cpu_stall(cpu_stall));

  pfsa_fw_model fw (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // A stalled core must find every address channel closed.
  always @(posedge aclk) begin
    if (cpu_stall === 1'h1) begin
      stall_cyc++;
      `CHK({awready, wready, arready}, 3'h0)
    end
  end

  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    fw.rd(a, rv, r);
    `CHK(rv, {24'h0, e})
  endtask : rchk

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rchk(8'(i * 4), (i == 6) ? 8'h02 : 8'h00);
    end
    fw.rd(8'h1C, rv, r);
    `CHK(r, pfsa_pkg::RESP_SLVERR)
    fw.wr(8'h01, 8'h55, r);
    `CHK(r, pfsa_pkg::RESP_SLVERR)
    fw.wr(pfsa_pkg::OFS_ADR_HI, 8'hFF, r);
    rchk(pfsa_pkg::OFS_ADR_HI, 8'h1F);
    fw.wr(pfsa_pkg::OFS_DAT_HI, 8'hFF, r);
    rchk(pfsa_pkg::OFS_DAT_HI, 8'h3F);
    s0 = stall_cyc;
    fw.flash_write(13'h0123, 14'h3ABC);
    // Two setup cycles, one hand-off into and one out of the array.
    `CHK(stall_cyc - s0, PC + 4)
    rchk(pfsa_pkg::OFS_CTL, 8'h80);
    fw.flash_write(13'h1FFF, 14'h0001);
    fw.flash_read(13'h0123, fd);
    `CHK(fd, 14'h3ABC)
    rchk(pfsa_pkg::OFS_CTL, 8'h80);
    fw.flash_read(13'h1FFF, fd);
    `CHK(fd, 14'h0001)
    fw.wr(pfsa_pkg::OFS_ADR_LO, 8'h23, r);
    repeat (4) @(posedge aclk);
    rchk(pfsa_pkg::OFS_DAT_LO, 8'h01);
    // Refused starts: same-access enable, bad key, broken run, protected.
    for (int k = 0; k < 4; k++) begin
      wp <= (k != 3);
      fw.wr(pfsa_pkg::OFS_DAT_LO, 8'h00, r);
      fw.wr(pfsa_pkg::OFS_CTL, (k == 0) ? 8'h80 : 8'h84, r);
      fw.wr(pfsa_pkg::OFS_UNLOCK, pfsa_pkg::UNLOCK_KEY1, r);
      if (k == 2) begin
        fw.wr(pfsa_pkg::OFS_ADR_LO, 8'h23, r);
      end
      fw.wr(pfsa_pkg::OFS_UNLOCK,
            (k == 1) ? 8'hAB : pfsa_pkg::UNLOCK_KEY2, r);
      s0 = stall_cyc;
      fw.wr(pfsa_pkg::OFS_CTL, 8'h86, r);
      repeat (4) @(posedge aclk);
      `CHK(stall_cyc - s0, 0)
      rchk(pfsa_pkg::OFS_CTL, 8'h8C);
      fw.wr(pfsa_pkg::OFS_CTL, 8'h80, r);
    end
    rchk(pfsa_pkg::OFS_STATUS, 8'h00);
    wp <= 1'h1;
    fw.flash_read(13'h0123, fd);
    `CHK(fd, 14'h3ABC)
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
